// ### hw/scl_defines.vh
`ifndef SCL_DEFINES_VH
`define SCL_DEFINES_VH

// register indices on the plain register port
`define SCL_ADDR_W        4
`define SCL_REG_CMD3      4'h0
`define SCL_REG_CMD6      4'h1
`define SCL_REG_ANS7A     4'h2
`define SCL_REG_ANS8A     4'h3
`define SCL_REG_CLEAR     4'h4
`define SCL_REG_STATUS    4'h5

// command frame 3 field positions
`define SCL_VSR_BIT       6
`define SCL_ISR_BIT       7
`define SCL_BYP_BIT       8
`define SCL_CL_LO         9
`define SCL_CL_HI         10
// command frame 6 field position
`define SCL_THERMAL_SLOPE_BYPASS_ENABLE_BIT      10
// answer frame 7a positions
`define SCL_VOLTAGE_SLOPE_READBACK_BIT  7
`define SCL_ISR_ECHO_BIT  8
`define SCL_BYP_ECHO_BIT  9
`define SCL_CL_ECHO_LO    10
`define SCL_CL_ECHO_HI    11
`define SCL_THERMAL_SLOPE_BYPASS_READBACK_BIT 12
// answer frame 8a position
`define SCL_LIMIT_BIT     3

// reset values
`define SCL_VSR_RST       1'h1
`define SCL_ISR_RST       1'h1
`define SCL_BYP_RST       1'h0
`define SCL_THERMAL_SLOPE_BYPASS_ENABLE_RST      1'h0
`define SCL_CL_RST        2'h1

// timing, in ns, and cycle counts at 100 MHz
`define SCL_CLK_NS        10
`define SCL_T_LIMH_NS     10000
`define SCL_T_LIML_NS     10000
`define SCL_T_DIAG_HI_NS  20000
`define SCL_T_DIAG_LO_NS  40000
`define SCL_T_OFF_NS      40000
`define SCL_T_LIMH_CYC    ((`SCL_T_LIMH_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS)
`define SCL_T_LIML_CYC    ((`SCL_T_LIML_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS)
`define SCL_T_DIAG_HI_CYC ((`SCL_T_DIAG_HI_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS)
`define SCL_T_DIAG_LO_CYC ((`SCL_T_DIAG_LO_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS)
`define SCL_T_OFF_CYC     ((`SCL_T_OFF_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS)

`endif

// ### hw/scl_slew_chop_ctrl.v
`timescale 1ns/10ps
`include "scl_defines.vh"
// Overview of operation
// - answer 7a bit 7 echoes voltage slope select, 1 fast, default fast.
// - warning with thermal enable, limit flag, overcurrent low or bypass force very fast.
// - slope bypass enable is command 3 bit 8, resets 0.
// - answer 7a bit 9 mirrors slope bypass enable, default 0.
// - thermal warning with thermal bypass enabled forces voltage slope very fast and drops current slope control.
// - thermal bypass disabled keeps selected slope mode during warning.
// - thermal slope bypass enable is command 6 bit 10, resets 0.
// - a readback bit mirrors the thermal slope bypass enable, default 0.
// - reaching upper threshold latches limit flag; cleared by serial, disable, reset.
// - limit flag appears at answer 8a bit 3, default 0.
// - overcurrent in window sets that transistor's bits and tristates the bridge.
// - window end clean: leave limit mode, high off, lows on, hold minimum off time.
// - pulse input fall inside window also starts minimum off timer.
// - window length chosen from supply level at start, frozen afterwards.
// - limit flag clears once current drops below lower threshold plus hysteresis.
// - exit limitation after low filter time and minimum off time; bypass stays.
// - programmed slopes restored when below lower threshold and pulse input low.
// - in two-input mode restore when toggling bridge input is low.
// - chop threshold select is command 3 bits 10:9, reset 01.
// - lower threshold tracks upper, about half an ampere below.
// - answer 7a bits 11:10 mirror chop threshold select, reset 01.
// - voltage slope select is command 3 bit 6, resets 1 fast.
// - current slope select is command 3 bit 7, resets 1 fast.
module scl_slew_chop_ctrl #(
  parameter T_LIMH_CYC    = `SCL_T_LIMH_CYC,
  parameter T_LIML_CYC    = `SCL_T_LIML_CYC,
  parameter T_DIAG_HI_CYC = `SCL_T_DIAG_HI_CYC,
  parameter T_DIAG_LO_CYC = `SCL_T_DIAG_LO_CYC,
  parameter T_OFF_CYC     = `SCL_T_OFF_CYC,
  parameter CNT_W         = 16
) (
  input  wire        i_ref_clk,          // 100 MHz clock
  input  wire        i_resetn,           // async reset, low
  input  wire [3:0]  i_addr,             // register index
  input  wire [15:0] i_wdata,            // write data
  input  wire        i_wr,               // write strobe
  input  wire        i_rd,               // read strobe
  output reg  [15:0] o_rdata,            // read data, cycle after strobe
  input  wire        i_pwm,              // pulse-width input (pin)
  input  wire        i_bridge_input_a,   // two-input mode input a (pin)
  input  wire        i_bridge_input_b,   // two-input mode input b (pin)
  input  wire        i_two_input_mode,   // 1: two-input drive mode
  input  wire        i_disable,          // disable input (pin), clears flag
  input  wire        i_thermal_warning,  // junction above warning level
  input  wire        i_overcurrent_condition_n, // low: overcurrent condition
  input  wire        i_above_high_limit, // current above upper threshold
  input  wire        i_below_low_limit,  // current below lower threshold
  input  wire        i_below_low_hyst,   // below lower threshold plus hysteresis
  input  wire [3:0]  i_overcurrent_level,// filtered per transistor: hsa,hsb,lsa,lsb
  input  wire        i_supply_normal,    // supply above normal level
  output reg  [1:0]  o_chop_threshold,   // selected range for analog comparators
  output reg         o_voltage_very_fast,// voltage slope forced very fast
  output reg         o_current_uncontrolled, // current slope control dropped
  output reg         o_voltage_slope,    // programmed voltage slope, 1 fast
  output reg         o_current_slope,    // programmed current slope, 1 fast
  output reg         o_variable_voltage_limit_mode, // limit mode still allowed
  output reg         o_high_side_off,    // high-side forced off
  output reg         o_low_sides_on,     // both low sides forced on
  output reg         o_tristate,         // bridge tristate after overcurrent
  output reg         o_oc_supervision    // overcurrent supervision enabled
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_WIN   = 3'h1;
  localparam ST_OFF   = 3'h2;
  localparam ST_TRI   = 3'h3;
  localparam ST_CHECK = 3'h4;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops each
  reg [4:0] sync1_ff;
  reg [4:0] sync2_ff;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end else begin
      sync1_ff <= {i_supply_normal, i_disable, i_bridge_input_b,
                   i_bridge_input_a, i_pwm};
      sync2_ff <= sync1_ff;
    end
  end
  wire pwm_s   = sync2_ff[0];
  wire in_a_s  = sync2_ff[1];
  wire in_b_s  = sync2_ff[2];
  wire dis_s   = sync2_ff[3];
  wire vnorm_s = sync2_ff[4];

  //////////////////////////////////////////////////////////////////////////
  // configuration registers
  reg        vsr_ff;
  reg        isr_ff;
  reg        byp_ff;
  reg        thermal_slope_bypass_enable_ff;
  reg [1:0]  cl_ff;
  reg        limit_ff;
  reg [3:0]  ocdiag_ff;
  reg [2:0]  state_ff;
  reg        restore_ff;
  reg [CNT_W-1:0] hcnt_ff;
  reg [CNT_W-1:0] lcnt_ff;
  reg [CNT_W-1:0] win_ff;
  reg [CNT_W-1:0] off_ff;
  reg        off_run_ff;
  reg        pwm_d_ff;
  reg        toggle_b_ff;
  reg        in_a_d_ff;
  reg        in_b_d_ff;

  wire wr_cmd3 = i_wr && (i_addr == `SCL_REG_CMD3);
  wire wr_cmd6 = i_wr && (i_addr == `SCL_REG_CMD6);
  wire wr_clr  = i_wr && (i_addr == `SCL_REG_CLEAR) && i_wdata[`SCL_LIMIT_BIT];

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      vsr_ff  <= `SCL_VSR_RST;
      isr_ff  <= `SCL_ISR_RST;
      byp_ff  <= `SCL_BYP_RST;
      thermal_slope_bypass_enable_ff <= `SCL_THERMAL_SLOPE_BYPASS_ENABLE_RST;
      cl_ff   <= `SCL_CL_RST;
    end else begin
      if (wr_cmd3) begin
        vsr_ff <= i_wdata[`SCL_VSR_BIT];
        isr_ff <= i_wdata[`SCL_ISR_BIT];
        byp_ff <= i_wdata[`SCL_BYP_BIT];
        cl_ff  <= i_wdata[`SCL_CL_HI:`SCL_CL_LO];
      end
      if (wr_cmd6)
        thermal_slope_bypass_enable_ff <= i_wdata[`SCL_THERMAL_SLOPE_BYPASS_ENABLE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // edge detection on synchronised inputs
  wire pwm_fall = pwm_d_ff && !pwm_s;
  wire in_a_edge = in_a_d_ff ^ in_a_s;
  wire in_b_edge = in_b_d_ff ^ in_b_s;
  // the toggling input is the one seen to change last
  wire nxt_toggle_b = in_b_edge ? 1'b1 : (in_a_edge ? 1'b0 : toggle_b_ff);
  wire drive_in = i_two_input_mode ? (nxt_toggle_b ? in_b_s : in_a_s)
                                   : pwm_s;
  wire drive_fall = i_two_input_mode ? (nxt_toggle_b ? (in_b_d_ff && !in_b_s)
                                                     : (in_a_d_ff && !in_a_s))
                                     : pwm_fall;

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pwm_d_ff    <= 1'b0;
      in_a_d_ff   <= 1'b0;
      in_b_d_ff   <= 1'b0;
      toggle_b_ff <= 1'b0;
    end else begin
      pwm_d_ff    <= pwm_s;
      in_a_d_ff   <= in_a_s;
      in_b_d_ff   <= in_b_s;
      toggle_b_ff <= nxt_toggle_b;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // current limitation sequence
  wire hcnt_done = (hcnt_ff >= T_LIMH_CYC[CNT_W-1:0]);
  wire lcnt_done = (lcnt_ff >= T_LIML_CYC[CNT_W-1:0]);
  wire off_done  = !off_run_ff && (off_ff == {CNT_W{1'b0}});
  wire oc_hit    = |i_overcurrent_level;

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff   <= ST_IDLE;
      hcnt_ff    <= {CNT_W{1'b0}};
      lcnt_ff    <= {CNT_W{1'b0}};
      win_ff     <= {CNT_W{1'b0}};
      off_ff     <= {CNT_W{1'b0}};
      off_run_ff <= 1'b0;
      ocdiag_ff  <= 4'h0;
      restore_ff <= 1'b1;
    end else begin
      // high-limit filter runs while above the upper threshold
      hcnt_ff <= i_above_high_limit ? (hcnt_done ? hcnt_ff : hcnt_ff + 1'b1)
                                    : {CNT_W{1'b0}};
      // low-limit filter runs while below the lower threshold
      lcnt_ff <= i_below_low_limit ? (lcnt_done ? lcnt_ff : lcnt_ff + 1'b1)
                                   : {CNT_W{1'b0}};
      // minimum recirculation timer
      if (off_run_ff) begin
        off_run_ff <= 1'b0;
        off_ff     <= T_OFF_CYC[CNT_W-1:0];
      end else if (off_ff != {CNT_W{1'b0}}) begin
        off_ff <= off_ff - 1'b1;
      end
      // programmed slopes come back once low and drive input low
      if (i_below_low_limit && !drive_in && state_ff == ST_IDLE)
        restore_ff <= 1'b1;
      case (state_ff)
        ST_IDLE: begin
          if (hcnt_done) begin
            state_ff   <= ST_WIN;
            restore_ff <= 1'b0;
            win_ff     <= vnorm_s ? T_DIAG_HI_CYC[CNT_W-1:0]
                                  : T_DIAG_LO_CYC[CNT_W-1:0];
          end
        end
        ST_WIN: begin
          if (drive_fall)
            off_run_ff <= 1'b1;
          if (oc_hit) begin
            ocdiag_ff <= ocdiag_ff | i_overcurrent_level;
            state_ff  <= ST_TRI;
          end else if (win_ff <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
            state_ff <= ST_OFF;
            if (!drive_fall && off_done)
              off_run_ff <= 1'b1;
          end else begin
            win_ff <= win_ff - 1'b1;
          end
        end
        ST_OFF: begin
          state_ff <= ST_CHECK;
        end
        ST_CHECK: begin
          if (lcnt_done && off_done)
            state_ff <= ST_IDLE;
        end
        ST_TRI: begin
          if (dis_s)
            state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
      if (wr_clr)
        ocdiag_ff <= 4'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // chop-limit flag: set wins over any clear
  wire limit_set = (state_ff == ST_IDLE) && hcnt_done;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn)
      limit_ff <= 1'b0;
    else if (limit_set)
      limit_ff <= 1'b1;
    else if (wr_clr || dis_s || (i_below_low_hyst && state_ff != ST_WIN))
      limit_ff <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // slope mode and bridge override outputs
  wire therm_byp = i_thermal_warning && thermal_slope_bypass_enable_ff;
  wire in_limit  = (state_ff != ST_IDLE) || !restore_ff;
  wire force_vf  = therm_byp || limit_ff || !i_overcurrent_condition_n ||
                   byp_ff || in_limit;
  wire hold_off  = (state_ff == ST_OFF) || (state_ff == ST_CHECK);
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_chop_threshold              <= `SCL_CL_RST;
      o_voltage_very_fast           <= 1'b0;
      o_current_uncontrolled        <= 1'b0;
      o_voltage_slope               <= `SCL_VSR_RST;
      o_current_slope               <= `SCL_ISR_RST;
      o_variable_voltage_limit_mode <= 1'b1;
      o_high_side_off               <= 1'b0;
      o_low_sides_on                <= 1'b0;
      o_tristate                    <= 1'b0;
      o_oc_supervision              <= 1'b0;
    end else begin
      o_chop_threshold              <= cl_ff;
      o_voltage_very_fast           <= force_vf;
      o_current_uncontrolled        <= force_vf;
      o_voltage_slope               <= vsr_ff;
      o_current_slope               <= isr_ff;
      o_variable_voltage_limit_mode <= !hold_off;
      o_high_side_off               <= hold_off && !(state_ff == ST_CHECK && off_done);
      o_low_sides_on                <= hold_off && !(state_ff == ST_CHECK && off_done);
      o_tristate                    <= (state_ff == ST_TRI);
      o_oc_supervision              <= (state_ff == ST_WIN);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after strobe
  reg [15:0] nxt_rdata;
  always @* begin
    nxt_rdata = 16'h0000;
    case (i_addr)
      `SCL_REG_CMD3: begin
        nxt_rdata[`SCL_VSR_BIT] = vsr_ff;
        nxt_rdata[`SCL_ISR_BIT] = isr_ff;
        nxt_rdata[`SCL_BYP_BIT] = byp_ff;
        nxt_rdata[`SCL_CL_HI:`SCL_CL_LO] = cl_ff;
      end
      `SCL_REG_CMD6: nxt_rdata[`SCL_THERMAL_SLOPE_BYPASS_ENABLE_BIT] = thermal_slope_bypass_enable_ff;
      `SCL_REG_ANS7A: begin
        nxt_rdata[`SCL_VOLTAGE_SLOPE_READBACK_BIT] = vsr_ff;
        nxt_rdata[`SCL_ISR_ECHO_BIT] = isr_ff;
        nxt_rdata[`SCL_BYP_ECHO_BIT] = byp_ff;
        nxt_rdata[`SCL_CL_ECHO_HI:`SCL_CL_ECHO_LO] = cl_ff;
        nxt_rdata[`SCL_THERMAL_SLOPE_BYPASS_READBACK_BIT] = thermal_slope_bypass_enable_ff;
      end
      `SCL_REG_ANS8A: nxt_rdata[`SCL_LIMIT_BIT] = limit_ff;
      `SCL_REG_STATUS: nxt_rdata = {9'h000, state_ff, ocdiag_ff};
      default: nxt_rdata = 16'h0000;
    endcase
  end
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn)
      o_rdata <= 16'h0000;
    else if (i_rd)
      o_rdata <= nxt_rdata;
    else
      o_rdata <= 16'h0000;
  end

endmodule

// ### testbench/scl_load_model.sv
`timescale 1ns/10ps
module scl_load_model (
  input  wire       i_ref_clk,        // clock
  input  wire [1:0] i_level,          // 0 low, 1 mid, 2 high, 3 hyst band
  output reg        o_above_high,     // above upper threshold
  output reg        o_below_low,      // below lower threshold
  output reg        o_below_low_hyst  // below lower threshold plus hyst
);
  //////////////////////////////////////////////////////////////////////
  // comparators stay consistent: lower threshold sits under upper one
  always @(posedge i_ref_clk) begin
    o_above_high     <= (i_level == 2'h2);
    o_below_low      <= (i_level == 2'h0);
    o_below_low_hyst <= (i_level == 2'h0) || (i_level == 2'h3);
  end
endmodule

// ### testbench/scl_chk_assertions.sv
`timescale 1ns/10ps
module scl_chk #(
  parameter T_DIAG_LO_CYC = 8
) (
  input wire        i_ref_clk,                     // clock
  input wire        i_resetn,                      // async reset, low
  input wire [3:0]  i_addr,                        // register index
  input wire        i_rd,                          // read strobe
  input wire [15:0] o_rdata,                       // read data
  input wire        i_overcurrent_condition_n,     // low: overcurrent
  input wire [3:0]  i_overcurrent_level,           // per transistor
  input wire [1:0]  o_chop_threshold,              // range out
  input wire        o_voltage_slope,               // programmed slope
  input wire        o_voltage_very_fast,           // forced very fast
  input wire        o_current_uncontrolled,        // current control off
  input wire        o_variable_voltage_limit_mode, // limit mode allowed
  input wire        o_high_side_off,               // high side forced off
  input wire        o_low_sides_on,                // low sides forced on
  input wire        o_tristate,                    // bridge tristate
  input wire        o_oc_supervision               // window running
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  reg [15:0] win_cnt_ff;
  //////////////////////////////////////////////////////////////////////
  // run length of the short-check window
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      win_cnt_ff <= 16'h0;
    end else begin
      win_cnt_ff <= o_oc_supervision ? win_cnt_ff + 16'h1 : 16'h0;
    end
  end
  //////////////////////////////////////////////////////////////////////
  a_read_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
    else $error("read data not zero outside read cycle");
  a_echo_voltage: assert property ($past(i_rd) && $past(i_addr) == 4'h2
    |-> o_rdata[7] == o_voltage_slope) else $error("voltage echo mismatch");
  a_echo_chop_sel: assert property ($past(i_rd) && $past(i_addr) == 4'h2
    |-> o_rdata[11:10] == o_chop_threshold) else $error("chop echo mismatch");
  a_noc_very_fast: assert property (!i_overcurrent_condition_n
    |-> ##[1:3] o_voltage_very_fast) else $error("no very fast on overcurrent");
  a_drop_together: assert property ($rose(o_voltage_very_fast)
    |-> o_current_uncontrolled) else $error("current control kept");
  a_freewheel_pair: assert property (o_high_side_off
    |-> o_low_sides_on && !o_variable_voltage_limit_mode) else $error("bad freewheel");
  a_window_bound: assert property (win_cnt_ff <= T_DIAG_LO_CYC + 1)
    else $error("window too long");
  a_oc_tristate: assert property (o_oc_supervision && i_overcurrent_level != 4'h0
    |-> ##[1:3] o_tristate) else $error("no tristate on overcurrent");
  a_reset_range: assert property ($rose(i_resetn) |-> o_chop_threshold == 2'h1)
    else $error("chop range not 01 after reset");
  c_window: cover property ($rose(o_oc_supervision));
  c_freewheel: cover property ($rose(o_high_side_off));
  c_tristate: cover property ($rose(o_tristate));
endmodule

// ### testbench/tb.sv
`timescale 1ns/10ps
bind scl_slew_chop_ctrl scl_chk #(.T_DIAG_LO_CYC(T_DIAG_LO_CYC)) chk (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_overcurrent_condition_n(i_overcurrent_condition_n),
  .i_overcurrent_level(i_overcurrent_level), .o_chop_threshold(o_chop_threshold),
  .o_voltage_slope(o_voltage_slope), .o_voltage_very_fast(o_voltage_very_fast),
  .o_current_uncontrolled(o_current_uncontrolled), .o_tristate(o_tristate),
  .o_variable_voltage_limit_mode(o_variable_voltage_limit_mode),
  .o_high_side_off(o_high_side_off), .o_low_sides_on(o_low_sides_on),
  .o_oc_supervision(o_oc_supervision));
module tb;
  logic        i_ref_clk, i_resetn, i_wr, i_rd, i_pwm, i_disable, i_thermal_warning, oc_n;
  logic [3:0]  i_addr, oc_lvl;
  logic [15:0] i_wdata, rv;
  logic [1:0]  load_level;
  logic        in_a, in_b, two_mode, vnorm;
  wire         cunc, vsl, isl;
  wire  [15:0] o_rdata;
  wire  [1:0]  chop;
  wire         hi, lo, hyst, vfast, hs_off, ls_on, variable_voltage_limit_mode, tri_st, sup;
  int          failures, checked, i, n;
  //////////////////////////////////////////////////////////////////////
  scl_load_model load (.i_ref_clk(i_ref_clk), .i_level(load_level), .o_above_high(hi),
    .o_below_low(lo), .o_below_low_hyst(hyst));
  scl_slew_chop_ctrl #(.T_LIMH_CYC(8), .T_LIML_CYC(8), .T_DIAG_HI_CYC(8),
    .T_DIAG_LO_CYC(12), .T_OFF_CYC(8)) dut (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pwm(i_pwm), .i_bridge_input_a(in_a),
    .i_bridge_input_b(in_b), .i_two_input_mode(two_mode), .i_disable(i_disable),
    .i_thermal_warning(i_thermal_warning), .i_overcurrent_condition_n(oc_n),
    .i_above_high_limit(hi), .i_below_low_limit(lo), .i_below_low_hyst(hyst),
    .i_overcurrent_level(oc_lvl), .i_supply_normal(vnorm), .o_chop_threshold(chop),
    .o_voltage_very_fast(vfast), .o_current_uncontrolled(cunc), .o_voltage_slope(vsl),
    .o_current_slope(isl), .o_variable_voltage_limit_mode(variable_voltage_limit_mode), .o_high_side_off(hs_off),
    .o_low_sides_on(ls_on), .o_tristate(tri_st), .o_oc_supervision(sup));
  //////////////////////////////////////////////////////////////////////
  // bus cycles and comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task automatic stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_fields;
    rd(4'h2);
    chk(rv & 16'h1F80, 16'h0580); // echo defaults
    rd(4'h3);
    chk(rv, 16'h0000); // flag default
    rd(4'hF);
    chk(rv, 16'h0000);
    for (i = 0; i < 4; i++) begin
      wr(4'h0, {5'h0, i[1:0], 9'h100}); // slow, bypass
      rd(4'h2);
      chk(rv & 16'h0F80, {4'h0, i[1:0], 10'h200}); // echo
      chk({14'h0, chop}, {14'h0, i[1:0]}); // range out
      chk({15'h0, vfast}, 16'h0001); // bypass forces
      chk({15'h0, cunc}, 16'h0001); // current control dropped
      chk({14'h0, vsl, isl}, 16'h0000); // slow slopes out
    end
    wr(4'h0, 16'h02C0);
    wr(4'h1, 16'h0400); // thermal bypass on
    rd(4'h2);
    chk(rv & 16'h1000, 16'h1000); // thermal echo
    i_thermal_warning <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    chk({15'h0, vfast}, 16'h0001); // warm and enabled
    wr(4'h1, 16'h0000);
    repeat (4) @(posedge i_ref_clk);
    chk({15'h0, vfast}, 16'h0000); // warm but disabled
    i_thermal_warning <= 1'b0;
    oc_n <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    chk({15'h0, vfast}, 16'h0001); // overcurrent condition
    oc_n <= 1'b1;
    $display("test fields done");
  endtask
  task automatic t_limit;
    i_pwm <= 1'b1;
    load_level <= 2'h2;
    for (i = 0; i < 40 && sup !== 1'b1; i++) @(posedge i_ref_clk);
    rd(4'h3);
    chk(rv, 16'h0008); // flag latched
    chk({15'h0, vfast}, 16'h0001); // very fast
    for (i = 0; i < 40 && hs_off !== 1'b1; i++) @(posedge i_ref_clk);
    chk({14'h0, ls_on, variable_voltage_limit_mode}, 16'h0002); // freewheel
    load_level <= 2'h3;
    for (n = 0; n < 60 && hs_off === 1'b1; n++) @(posedge i_ref_clk);
    rd(4'h3);
    chk(rv, 16'h0000); // flag cleared
    load_level <= 2'h0;
    for (i = 0; i < 30; i++) begin
      rd(4'h5);
      if (rv[6:4] == 3'h0)
        break;
    end
    chk(rv & 16'h0070, 16'h0000); // left limitation
    chk({15'h0, i >= 3 && n >= 6}, 16'h0001); // low filter and off time held
    chk({15'h0, vfast}, 16'h0001); // bypass kept, input high
    i_pwm <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    chk({15'h0, vfast}, 16'h0000); // slopes restored
    $display("test limit done");
  endtask
  task automatic t_short;
    load_level <= 2'h2;
    for (i = 0; i < 40 && sup !== 1'b1; i++) @(posedge i_ref_clk);
    oc_lvl <= 4'h4;
    for (i = 0; i < 10 && tri_st !== 1'b1; i++) @(posedge i_ref_clk);
    oc_lvl <= 4'h0;
    load_level <= 2'h1;
    chk({15'h0, tri_st}, 16'h0001); // tristate
    rd(4'h5);
    chk(rv & 16'h000F, 16'h0004); // low side a bit
    wr(4'h4, 16'h0008);
    rd(4'h3);
    chk(rv, 16'h0000); // serial clear
    i_disable <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    chk({15'h0, tri_st}, 16'h0000); // disable releases
    i_disable <= 1'b0;
    load_level <= 2'h0;
    $display("test short done");
  endtask
  task automatic t_two;
    vnorm <= 1'b0;
    two_mode <= 1'b1;
    in_a <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    load_level <= 2'h2;
    for (i = 0; i < 40 && sup !== 1'b1; i++) @(posedge i_ref_clk);
    vnorm <= 1'b1;
    for (n = 0; n < 40 && sup === 1'b1; n++) @(posedge i_ref_clk);
    chk({15'h0, n >= 10 && n <= 13}, 16'h0001); // low-supply window kept
    load_level <= 2'h0;
    repeat (40) @(posedge i_ref_clk);
    rd(4'h5);
    chk(rv & 16'h0070, 16'h0000); // exited limitation
    chk({15'h0, vfast}, 16'h0001); // toggling input a high
    in_a <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    chk({15'h0, vfast}, 16'h0000); // restored on input a low
    two_mode <= 1'b0;
    $display("test two-input done");
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    {i_resetn, i_wr, i_rd, i_pwm, i_disable, i_thermal_warning} = 6'h0;
    {oc_n, i_addr, oc_lvl, i_wdata, load_level} = {1'b1, 26'h0};
    {in_a, in_b, two_mode, vnorm} = 4'h1;
    repeat (16) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    t_fields;
    t_limit;
    t_short;
    t_two;
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    failures++;
    stop_test;
  end
endmodule
